/* File: rtl/ulpss_pkg.sv */
// Constants and types for the link start-up sequencer
`default_nettype none

package ulpss_pkg;
	localparam int unsigned CLK_HZ         = 20_000_000;
	// Shortest low time of the reset pin, in nanoseconds
	localparam int unsigned RESET_MIN_NS   = 1000;
	localparam int unsigned RESET_MIN_CYC  =
		(RESET_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	// Reference edges counted before lock is believed; plain default
	localparam int unsigned LOCK_EDGES     = 64;
	// Reference silence (cycles) that drops lock
	localparam int unsigned REF_LOST_CYC   = 16;
	localparam logic [7:0]  BUS_IDLE       = 8'h00;
	localparam logic [1:0]  REG_LEVEL_RST  = 2'h0;
	localparam logic        AUTO_RESUME_RST = 1'b0;

	typedef enum logic [2:0] {
		ULPSS_RESET,
		ULPSS_WAIT_LOCK,
		ULPSS_WAIT_STP,
		ULPSS_RUN,
		ULPSS_LOW_POWER
	} ulpss_state_e;
endpackage

`default_nettype wire

/* File: rtl/ulpss_ref_monitor.sv */
// Reference clock edge detection and lock model
`default_nettype none

module ulpss_ref_monitor #(
	parameter int unsigned LOCK_EDGES = ulpss_pkg::LOCK_EDGES,
	parameter int unsigned LOST_CYC   = ulpss_pkg::REF_LOST_CYC
) (
	input  wire logic i_clk,
	input  wire logic i_reset_n,
	input  wire logic i_enable,
	input  wire logic i_ref,
	output logic      o_ref_rise,
	output logic      o_locked
);
	// Counters are 16 bits wide; refuse counts they cannot hold
	if (LOCK_EDGES < 1 || LOCK_EDGES > 65535 || LOST_CYC < 2 ||
	    LOST_CYC > 65535) begin : g_bad_param
		$error("ulpss_ref_monitor: bad parameter");
	end

	logic        ref_q;
	logic [15:0] edge_cnt;
	logic [15:0] quiet_cnt;

	// Rising edge only; falling edge ignored
	assign o_ref_rise = i_ref & ~ref_q;

	always_ff @(posedge i_clk) begin
		if (!i_reset_n)
			ref_q <= 1'b0;
		else
			ref_q <= i_ref;
	end

	// Silence counter; long silence means reference lost
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || o_ref_rise || !i_enable)
			quiet_cnt <= 16'h0000;
		else if (quiet_cnt != 16'(LOST_CYC))
			quiet_cnt <= quiet_cnt + 16'h0001;
	end

	// Lock counted from the first edge after enable
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || !i_enable) begin
			edge_cnt <= 16'h0000;
			o_locked <= 1'b0;
		end else if (quiet_cnt == 16'(LOST_CYC)) begin
			edge_cnt <= 16'h0000;
			o_locked <= 1'b0;
		end else if (o_ref_rise && !o_locked) begin
			if (edge_cnt == 16'(LOCK_EDGES - 1))
				o_locked <= 1'b1;
			else
				edge_cnt <= edge_cnt + 16'h0001;
		end
	end
endmodule

`default_nettype wire

/* File: rtl/ulpss_top.sv */
// Start-up and reset sequencer for the low pin count link
`default_nettype none

module ulpss_top #(
	parameter int unsigned LOCK_EDGES = ulpss_pkg::LOCK_EDGES,
	parameter int unsigned LOST_CYC   = ulpss_pkg::REF_LOST_CYC
) (
	input  wire logic       i_clk,
	input  wire logic       i_reset_n,
	input  wire logic       i_por_done,
	input  wire logic       i_reset_in_pin,
	input  wire logic       i_reference_clock_in,
	input  wire logic       i_stp,
	input  wire logic       i_transceiver_supply,
	input  wire logic       i_low_power_req,
	input  wire logic       i_uart_mode,
	input  wire logic       i_auto_resume_wr,
	input  wire logic       i_auto_resume_val,
	input  wire logic       i_reg_level_wr,
	input  wire logic [1:0] i_reg_level_val,
	output logic            o_dir,
	output logic [7:0]      o_data,
	output logic            o_data_oe,
	output logic            o_pll_locked,
	output logic            o_phy_clock_run,
	output logic            o_sync_mode,
	output logic            o_usb_enable,
	output logic            o_reg_access,
	output logic            o_auto_resume_enable,
	output logic [1:0]      o_regulator_level_select,
	output logic [1:0]      o_regulator_level
);
	////////////////////////////////////////////////////////////////////
	// Reset pin qualification

	logic [15:0]           low_cnt;
	logic                  low_ok;
	logic                  pin_q;
	logic                  dev_run;
	ulpss_pkg::ulpss_state_e state;
	ulpss_pkg::ulpss_state_e next_state;
	logic                  ref_rise;
	logic                  locked;

	// Low-time counter is 16 bits wide
	if (ulpss_pkg::RESET_MIN_CYC > 65535) begin : g_bad_reset_cnt
		$error("ulpss_top: reset count too wide");
	end

	// Count low time of the reset pin
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || i_reset_in_pin)
			low_cnt <= 16'h0000;
		else if (low_cnt != 16'(ulpss_pkg::RESET_MIN_CYC))
			low_cnt <= low_cnt + 16'h0001;
	end

	// A low pulse long enough counts as a full reset
	always_ff @(posedge i_clk) begin
		if (!i_reset_n)
			low_ok <= 1'b0;
		else if (low_cnt == 16'(ulpss_pkg::RESET_MIN_CYC))
			low_ok <= 1'b1;
		else if (state != ulpss_pkg::ULPSS_RESET)
			low_ok <= 1'b0;
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n)
			pin_q <= 1'b0;
		else
			pin_q <= i_reset_in_pin;
	end

	// Device runs only with power-on done and pin high
	assign dev_run = i_por_done & i_reset_in_pin;

	////////////////////////////////////////////////////////////////////
	// Reference clock monitor

	ulpss_ref_monitor #(
		.LOCK_EDGES (LOCK_EDGES),
		.LOST_CYC   (LOST_CYC)
	) u_refmon (
		.i_clk      (i_clk),
		.i_reset_n  (i_reset_n),
		.i_enable   (dev_run),
		.i_ref      (i_reference_clock_in),
		.o_ref_rise (ref_rise),
		.o_locked   (locked)
	);

	////////////////////////////////////////////////////////////////////
	// Start-up state machine

	// Device owns the bus while waiting for lock or for stop low
	function automatic logic owns_bus(input ulpss_pkg::ulpss_state_e s);
		return (s == ulpss_pkg::ULPSS_WAIT_LOCK) ||
		       (s == ulpss_pkg::ULPSS_WAIT_STP);
	endfunction

	always_comb begin
		next_state = state;
		case (state)
			ulpss_pkg::ULPSS_RESET: begin
				if (dev_run)
					next_state = ulpss_pkg::ULPSS_WAIT_LOCK;
			end
			ulpss_pkg::ULPSS_WAIT_LOCK: begin
				if (locked)
					next_state = ulpss_pkg::ULPSS_WAIT_STP;
			end
			ulpss_pkg::ULPSS_WAIT_STP: begin
				if (!locked)
					next_state = ulpss_pkg::ULPSS_WAIT_LOCK;
				else if (!i_stp)
					next_state = ulpss_pkg::ULPSS_RUN;
			end
			ulpss_pkg::ULPSS_RUN: begin
				if (!locked)
					next_state = ulpss_pkg::ULPSS_WAIT_LOCK;
				else if (i_low_power_req)
					next_state = ulpss_pkg::ULPSS_LOW_POWER;
			end
			ulpss_pkg::ULPSS_LOW_POWER: begin
				if (i_stp)
					next_state = ulpss_pkg::ULPSS_WAIT_LOCK;
			end
			default: next_state = ulpss_pkg::ULPSS_RESET;
		endcase
		// Losing the pin or power-on returns to reset
		if (!dev_run)
			next_state = ulpss_pkg::ULPSS_RESET;
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n)
			state <= ulpss_pkg::ULPSS_RESET;
		else
			state <= next_state;
	end

	////////////////////////////////////////////////////////////////////
	// Link outputs

	// Direction held high until lock and stop low
	always_ff @(posedge i_clk) begin
		if (!i_reset_n)
			o_dir <= 1'b0;
		else
			o_dir <= owns_bus(next_state);
	end

	// Idle on the bus while direction is ours
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_data    <= ulpss_pkg::BUS_IDLE;
			o_data_oe <= 1'b0;
		end else begin
			o_data    <= ulpss_pkg::BUS_IDLE;
			o_data_oe <= owns_bus(next_state);
		end
	end

	// Status outputs
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_pll_locked    <= 1'b0;
			o_phy_clock_run <= 1'b0;
			o_sync_mode     <= 1'b0;
			o_usb_enable    <= 1'b0;
			o_reg_access    <= 1'b0;
		end else begin
			o_pll_locked    <= locked;
			// Link clock runs while locked except in low power, free of reference phase
			o_phy_clock_run <= locked &&
				(next_state != ulpss_pkg::ULPSS_LOW_POWER);
			o_sync_mode     <= (next_state == ulpss_pkg::ULPSS_RUN);
			o_reg_access    <= (next_state == ulpss_pkg::ULPSS_RUN);
			o_usb_enable    <= (next_state == ulpss_pkg::ULPSS_RUN) &&
			                   i_transceiver_supply;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Control bits, defaulted by either reset

	always_ff @(posedge i_clk) begin
		if (!i_reset_n || low_ok || (pin_q && !i_reset_in_pin) ||
		    state == ulpss_pkg::ULPSS_RESET) begin
			o_auto_resume_enable     <= ulpss_pkg::AUTO_RESUME_RST;
			o_regulator_level_select <= ulpss_pkg::REG_LEVEL_RST;
		end else if (state == ulpss_pkg::ULPSS_RUN) begin
			if (i_auto_resume_wr)
				o_auto_resume_enable <= i_auto_resume_val;
			if (i_reg_level_wr)
				o_regulator_level_select <= i_reg_level_val;
		end
	end

	// Regulator level follows select only in UART mode
	always_ff @(posedge i_clk) begin
		if (!i_reset_n)
			o_regulator_level <= ulpss_pkg::REG_LEVEL_RST;
		else if (i_uart_mode)
			o_regulator_level <= o_regulator_level_select;
		else
			o_regulator_level <= ulpss_pkg::REG_LEVEL_RST;
	end
endmodule

`default_nettype wire

/* File: sim/ulpss_top_asserts.sv */
// Port checker of the start-up sequencer
`default_nettype none
module ulpss_asserts (
	input wire logic       i_clk,
	input wire logic       i_reset_n,
	input wire logic       i_por_done,
	input wire logic       i_reset_in_pin,
	input wire logic       i_stp,
	input wire logic       i_transceiver_supply,
	input wire logic       i_uart_mode,
	input wire logic       o_dir,
	input wire logic [7:0] o_data,
	input wire logic       o_data_oe,
	input wire logic       o_sync_mode,
	input wire logic       o_usb_enable,
	input wire logic       o_reg_access,
	input wire logic       o_auto_resume_enable,
	input wire logic [1:0] o_regulator_level_select,
	input wire logic [1:0] o_regulator_level
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	// Bus handling and direction release
	a_bus_idle: assert property (
		o_dir |-> o_data == 8'h00 && o_data_oe) else $error("bus not idle");
	a_oe_follow: assert property (
		o_data_oe == o_dir) else $error("enable differs from direction");
	a_dir_release: assert property (
		$fell(o_dir) && i_reset_in_pin && $past(i_reset_in_pin)
		|-> o_sync_mode && $past(!i_stp)) else $error("early release");
	a_stp_hold: assert property (
		o_dir && i_stp && i_reset_in_pin && i_por_done |=> o_dir)
		else $error("direction dropped with stop high");
	a_rise_cause: assert property (
		$rose(o_dir) |-> $past(i_por_done && i_reset_in_pin))
		else $error("start without power-on and pin");
	a_sync_owns: assert property (
		o_sync_mode |-> !o_dir) else $error("run with direction high");
	a_pin_reset: assert property (
		!i_reset_in_pin ##1 !i_reset_in_pin |=> !o_dir
		&& !o_auto_resume_enable && o_regulator_level_select == 2'h0)
		else $error("pin low left state");
	a_supply_off: assert property (
		!i_transceiver_supply |=> !o_usb_enable
		&& o_reg_access == o_sync_mode) else $error("usb without supply");
	a_uart_level: assert property (
		!i_uart_mode |=> o_regulator_level == 2'h0)
		else $error("level outside uart mode");
	a_reset_quiet: assert property (
		$rose(i_reset_n) |-> !o_dir && !o_auto_resume_enable)
		else $error("outputs not at defaults");
endmodule
bind ulpss_top ulpss_asserts chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
	.i_por_done(i_por_done), .i_reset_in_pin(i_reset_in_pin), .i_stp(i_stp),
	.i_transceiver_supply(i_transceiver_supply), .i_uart_mode(i_uart_mode),
	.o_dir(o_dir), .o_data(o_data), .o_data_oe(o_data_oe),
	.o_sync_mode(o_sync_mode), .o_usb_enable(o_usb_enable),
	.o_reg_access(o_reg_access), .o_auto_resume_enable(o_auto_resume_enable),
	.o_regulator_level_select(o_regulator_level_select),
	.o_regulator_level(o_regulator_level));
`default_nettype wire

/* File: sim/ulpss_link_model.sv */
// Link-side model: reference clock, reset pin and stop line
`default_nettype none
module ulpss_link_model (
	input  wire logic i_clk,
	input  wire logic i_ref_en,
	input  wire logic i_pin_req,
	input  wire logic i_stp_req,
	input  wire logic i_dir,
	output logic      o_ref,
	output logic      o_pin,
	output logic      o_stp,
	output logic [7:0] o_cmd,
	output logic      o_cmd_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	// Reference toggles while enabled and parks low when stopped
	always @(posedge i_clk) begin
		o_ref <= i_ref_en ? ~o_ref : 1'b0;
	end
	// Pin and stop are always driven to a defined level
	always @(posedge i_clk) begin
		o_pin <= i_pin_req;
		o_stp <= i_stp_req;
	end
	// Link drives idle on the bus from one cycle after direction drops
	always @(posedge i_clk) begin
		o_cmd    <= ulpss_pkg::BUS_IDLE;
		o_cmd_oe <= !i_dir;
	end
endmodule
`default_nettype wire

/* File: sim/ulpss_top_tb.sv */
// Self-checking bench of the start-up sequencer
`default_nettype none
module ulpss_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk, rst_n, por, ref_en, pin_req, stp_req, supply, lp_req;
	logic       uart, ar_wr, ar_val, lv_wr, ref_w, pin_w, stp_w;
	logic       dir, oe, lock, crun, sync, usb, racc, ar;
	logic [1:0] lv_val, sel, lvl;
	logic [7:0] data, link_cmd;
	logic       link_oe;
	int         miscompares, check_count, cycles;
	ulpss_link_model link (.i_clk(clk), .i_ref_en(ref_en),
		.i_pin_req(pin_req), .i_stp_req(stp_req), .i_dir(dir),
		.o_ref(ref_w), .o_pin(pin_w), .o_stp(stp_w), .o_cmd(link_cmd),
		.o_cmd_oe(link_oe));
	ulpss_top #(.LOCK_EDGES(4), .LOST_CYC(4)) dut (.i_clk(clk),
		.i_reset_n(rst_n), .i_por_done(por), .i_reset_in_pin(pin_w),
		.i_reference_clock_in(ref_w), .i_stp(stp_w),
		.i_transceiver_supply(supply), .i_low_power_req(lp_req),
		.i_uart_mode(uart), .i_auto_resume_wr(ar_wr),
		.i_auto_resume_val(ar_val), .i_reg_level_wr(lv_wr),
		.i_reg_level_val(lv_val), .o_dir(dir), .o_data(data),
		.o_data_oe(oe), .o_pll_locked(lock), .o_phy_clock_run(crun),
		.o_sync_mode(sync), .o_usb_enable(usb), .o_reg_access(racc),
		.o_auto_resume_enable(ar), .o_regulator_level_select(sel),
		.o_regulator_level(lvl));
	// Compare and count
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask
	// Bounded wait for a direction level
	task automatic wait_dir(input logic v);
		for (int k = 0; k < 300 && dir !== v; k++) tick(1);
		check(dir, v);
	endtask
	task automatic give_verdict;
		$display("checks=%0d mismatches=%0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic t_startup;
		pin_req = 1'b1;
		tick(3);
		check(oe, 1'b1);
		check(data, 8'h00);
		wait_dir(1'b0);
		check(lock, 1'b1);
		check(sync, 1'b1);
		check(usb, 1'b1);
		check(crun, 1'b1);
		tick(1);
		check(link_oe, 1'b1);
		check(link_cmd, 8'h00);
	endtask
	task automatic t_ctrl;
		{ar_val, ar_wr, lv_wr, uart, lv_val} = 6'h3E;
		tick(1);
		{ar_wr, lv_wr} = 2'h0;
		tick(2);
		check(ar, 1'b1);
		check(lvl, 2'h2);
		uart = 1'b0;
		supply = 1'b0;
		tick(2);
		check(lvl, 2'h0);
		check({usb, racc}, 2'h1);
		supply = 1'b1;
	endtask
	task automatic t_refloss;
		ref_en = 1'b0;
		wait_dir(1'b1);
		check(crun, 1'b0);
		ref_en = 1'b1;
		wait_dir(1'b0);
	endtask
	task automatic t_lowpower;
		lp_req = 1'b1;
		tick(2);
		check(crun, 1'b0);
		lp_req = 1'b0;
		ref_en = 1'b0;
		tick(4);
		{stp_req, ref_en} = 2'h3;
		wait_dir(1'b1);
		tick(30);
		check(dir, 1'b1);
		stp_req = 1'b0;
		wait_dir(1'b0);
	endtask
	task automatic t_pinreset;
		pin_req = 1'b0;
		tick(25);
		check({dir, ar, sel, lock}, 8'h0);
		por = 1'b0;
		pin_req = 1'b1;
		tick(12);
		check(dir, 1'b0);
		por = 1'b1;
		wait_dir(1'b1);
		wait_dir(1'b0);
	endtask
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			give_verdict;
		end
	end
	initial begin
		{rst_n, por, ref_en, pin_req, stp_req, lp_req} = 6'h00;
		{uart, ar_wr, ar_val, lv_wr, lv_val, supply} = 7'h01;
		tick(2);
		{rst_n, por, ref_en} = 3'h7;
		t_startup;
		t_ctrl;
		t_refloss;
		t_lowpower;
		t_pinreset;
		give_verdict;
	end
endmodule
`default_nettype wire
